// ---- design/fsxu_defs.vh ----
/*
  bit positions, exception codes and constants of the float status and exception unit.
  assumes inclusion by bare name from design files.
*/
`ifndef FSXU_DEFS_VH
`define FSXU_DEFS_VH
`define FSXU_ERR_BIT      15
`define FSXU_GTD_BIT      14
`define FSXU_UV_BIT       11
`define FSXU_UF_BIT       10
`define FSXU_OVE_BIT      9
`define FSXU_CVE_BIT      8
`define FSXU_DBL_BIT      7
`define FSXU_LONG_BIT     6
`define FSXU_CHOP_BIT     5
`define FSXU_MAINT_BIT    4
`define FSXU_N_BIT        3
`define FSXU_Z_BIT        2
`define FSXU_V_BIT        1
`define FSXU_C_BIT        0
`define FSXU_LOAD_MASK    16'hcfff
`define FSXU_STS_RESET    16'h0000
`define FSXU_CODE_NONE    4'h0
`define FSXU_CODE_OPC     4'h2
`define FSXU_CODE_DIV0    4'h4
`define FSXU_CODE_CONV    4'h6
`define FSXU_CODE_OVF     4'h8
`define FSXU_CODE_UNF     4'ha
`define FSXU_CODE_UNDEF   4'hc
`define FSXU_CODE_MAINT   4'he
`define FSXU_VECTOR       9'h0a4
`define FSXU_STEP_SGL     5'h04
`define FSXU_STEP_DBL     5'h08
`define FSXU_EXP_BIAS_ADJ 8'h00
`define FSXU_AC_MAX_ANY   3'h5
`define FSXU_AC_MAX_MEM   3'h3
`define FSXU_MODE_AC      3'h0
`endif

// ---- design/fsxu_status_unit.v ----
/*
  status word, mode bits, exception prioritising and exception code/address capture of the float unit.
  assumes the datapath reports each finished operation as a one-cycle pulse with its flags,
  and the host cpu waits on op_done while busy is high.
*/
`timescale 1ns/100ps
`default_nettype none
`include "fsxu_defs.vh"

module fsxu_status_unit #(
  parameter ADDR_W     = 16,
  parameter FRAC_W     = 56,
  parameter SGL_FRAC_W = 24,
  parameter VAL_W      = 64,
  parameter WORD_W     = 16
) (
  // clock and reset
  input  wire              core_clk,
  input  wire              rst,
  // status load / store and system reset instruction
  input  wire              status_load_instr,
  input  wire [15:0]       status_load_data,
  input  wire              kernel_mode,
  input  wire              sys_reset_instr,
  output wire [15:0]       float_status_word,
  // operation report from the datapath
  input  wire              op_start,
  input  wire              op_done_in,
  input  wire [ADDR_W-1:0] op_addr,
  input  wire              res_negative,
  input  wire              res_zero,
  input  wire              res_minus_zero,
  input  wire              ex_div_zero,
  input  wire              ex_bad_opcode,
  input  wire              ex_overflow,
  input  wire              ex_underflow,
  input  wire              ex_conv_fail,
  input  wire              ex_conv_carry,
  input  wire              ex_undef_var,
  input  wire              ex_maint,
  // operand addressing check
  input  wire [2:0]        addr_mode,
  input  wire [2:0]        ac_sel,
  output wire              ac_illegal,
  output wire [4:0]        auto_step,
  // result steering to the datapath
  output wire              result_force_zero,
  output wire              double_precision_mode,
  output wire              long_integer_mode,
  output wire              chop_mode,
  output wire              maintenance_mode,
  // host handshake and interrupt
  output wire              busy,
  output wire              op_done,
  output reg               float_irq,
  output wire [8:0]        irq_vector,
  // exception registers
  output wire [3:0]        float_exception_code,
  output wire [ADDR_W-1:0] float_exception_address,
  // rounding of a fraction cut to length
  input  wire [FRAC_W-1:0] frac_chopped,
  input  wire              round_bit,
  output wire [FRAC_W-1:0] frac_result,
  output wire              frac_carry,
  // word order of a value moved to or from memory
  input  wire [VAL_W-1:0]  fp_value,
  input  wire [1:0]        mem_word_sel,
  output wire [WORD_W-1:0] mem_word
);

  reg  [15:0]       sts_q;
  reg  [15:0]       sts_d;
  reg  [3:0]        code_q;
  reg  [ADDR_W-1:0] addr_q;
  reg               busy_q;
  reg  [3:0]        code_d;
  reg               record;
  wire              bad_opc_all;

  localparam PAD_W = FRAC_W - SGL_FRAC_W;
  localparam WORDS = VAL_W / WORD_W;

  wire [FRAC_W-1:0] frac_keep;
  wire [FRAC_W-1:0] frac_lsb;
  wire [FRAC_W-1:0] frac_cut;
  wire [FRAC_W:0]   frac_sum;
  wire [WORD_W-1:0] word_at [0:WORDS-1];
  reg  [FRAC_W-1:0] frac_q;
  reg               frac_carry_q;
  reg  [WORD_W-1:0] mem_word_q;

  assign double_precision_mode = sts_q[`FSXU_DBL_BIT];
  assign long_integer_mode     = sts_q[`FSXU_LONG_BIT];
  assign chop_mode             = sts_q[`FSXU_CHOP_BIT];
  assign maintenance_mode      = sts_q[`FSXU_MAINT_BIT];

  // accumulator range per addressing mode
  assign ac_illegal = (addr_mode == `FSXU_MODE_AC) ? (ac_sel > `FSXU_AC_MAX_ANY)
                                                   : (ac_sel > `FSXU_AC_MAX_MEM);
  assign bad_opc_all = ex_bad_opcode | ac_illegal;
  assign auto_step = sts_q[`FSXU_DBL_BIT] ? `FSXU_STEP_DBL : `FSXU_STEP_SGL;

  // disabled overflow/underflow and any conversion failure store exact zero
  assign result_force_zero = (ex_underflow & ~sts_q[`FSXU_UF_BIT])
                           | (ex_overflow & ~sts_q[`FSXU_OVE_BIT])
                           | ex_conv_fail;

  // priority encode of recorded exceptions
  always @* begin
    record = 1'b1;
    code_d = `FSXU_CODE_NONE;
    if (bad_opc_all) begin
      code_d = `FSXU_CODE_OPC;
    end else if (ex_div_zero) begin
      code_d = `FSXU_CODE_DIV0;
    end else if (ex_undef_var && sts_q[`FSXU_UV_BIT]) begin
      code_d = `FSXU_CODE_UNDEF;
    end else if (res_minus_zero) begin
      code_d = `FSXU_CODE_UNDEF;
    end else if (ex_conv_fail && sts_q[`FSXU_CVE_BIT]) begin
      code_d = `FSXU_CODE_CONV;
    end else if (ex_overflow && sts_q[`FSXU_OVE_BIT]) begin
      code_d = `FSXU_CODE_OVF;
    end else if (ex_underflow && sts_q[`FSXU_UF_BIT]) begin
      code_d = `FSXU_CODE_UNF;
    end else if (ex_maint && sts_q[`FSXU_MAINT_BIT]) begin
      code_d = `FSXU_CODE_MAINT;
    end else begin
      record = 1'b0;
    end
  end

  // next status word
  always @* begin
    sts_d = sts_q;
    if (status_load_instr) begin
      sts_d = status_load_data & `FSXU_LOAD_MASK;
      if (!kernel_mode) begin
        sts_d[`FSXU_MAINT_BIT] = sts_q[`FSXU_MAINT_BIT] & status_load_data[`FSXU_MAINT_BIT];
      end
      // an exception recorded in the same cycle still leaves the error flag set
      if (op_done_in && record) begin
        sts_d[`FSXU_ERR_BIT] = 1'b1;
      end
    end else if (op_done_in) begin
      sts_d[`FSXU_N_BIT] = res_negative & ~result_force_zero;
      sts_d[`FSXU_Z_BIT] = res_zero | result_force_zero;
      sts_d[`FSXU_V_BIT] = ex_overflow;
      sts_d[`FSXU_C_BIT] = ex_conv_carry;
      if (record) begin
        sts_d[`FSXU_ERR_BIT] = 1'b1;
      end
    end
  end

  always @(posedge core_clk) begin
    if (rst) begin
      sts_q     <= `FSXU_STS_RESET;
      code_q    <= `FSXU_CODE_NONE;
      addr_q    <= {ADDR_W{1'b0}};
      busy_q    <= 1'b0;
      float_irq <= 1'b0;
    end else begin
      sts_q <= sts_d;
      if (op_start) begin
        busy_q <= 1'b1;
      end else if (op_done_in) begin
        busy_q <= 1'b0;
      end
      float_irq <= 1'b0;
      if (op_done_in && record) begin
        code_q    <= code_d;
        addr_q    <= op_addr;
        float_irq <= ~sts_q[`FSXU_GTD_BIT];
      end
    end
  end

  // rounding stage: the datapath hands over the fraction cut to length and the first bit it dropped
  assign frac_keep = double_precision_mode ? {FRAC_W{1'b1}}
                                           : {{SGL_FRAC_W{1'b1}}, {PAD_W{1'b0}}};
  assign frac_lsb  = double_precision_mode ? {{(FRAC_W-1){1'b0}}, 1'b1}
                                           : {{(SGL_FRAC_W-1){1'b0}}, 1'b1, {PAD_W{1'b0}}};
  assign frac_cut  = frac_chopped & frac_keep;
  // extra top bit keeps the carry of an all-ones fraction for renormalising downstream
  assign frac_sum  = {1'b0, frac_cut} + {1'b0, frac_lsb & {FRAC_W{round_bit}}};

  // word 0, at the lowest address, is the most significant word
  genvar w;
  generate
    for (w = 0; w < WORDS; w = w + 1) begin : g_word_order
      assign word_at[w] = fp_value[VAL_W-1-WORD_W*w -: WORD_W];
    end
  endgenerate

  always @(posedge core_clk) begin
    if (rst) begin
      frac_q       <= {FRAC_W{1'b0}};
      frac_carry_q <= 1'b0;
      mem_word_q   <= {WORD_W{1'b0}};
    end else begin
      frac_q       <= chop_mode ? frac_cut : frac_sum[FRAC_W-1:0];
      frac_carry_q <= ~chop_mode & frac_sum[FRAC_W];
      mem_word_q   <= word_at[mem_word_sel];
    end
  end

  // system reset instruction touches nothing here
  wire unused_sys_reset = sys_reset_instr;

  assign float_status_word       = sts_q;
  assign float_exception_code    = code_q;
  assign float_exception_address = addr_q;
  assign irq_vector              = `FSXU_VECTOR;
  assign busy                    = busy_q;
  assign op_done                 = op_done_in;
  assign frac_result             = frac_q;
  assign frac_carry              = frac_carry_q;
  assign mem_word                = mem_word_q;

endmodule // fsxu_status_unit
`default_nettype wire

// ---- tb/fsxu_host_model.sv ----
/* host cpu model: issues an operation, answers done later. assumes one clock. */
`timescale 1ns/100ps
`default_nettype none
module fsxu_host_model (
  // clock and request
  input  wire logic       core_clk,
  input  wire logic       go,
  input  wire logic [3:0] dly,
  // issue and completion
  output logic            op_start = 1'b0,
  output logic            op_done_in = 1'b0
);
  logic [3:0] cnt_q = 4'h0;
  logic       run_q = 1'b0;
  // done comes dly+1 cycles after the start; the cpu waits on it
  always @(posedge core_clk) begin
    op_start <= go;
    op_done_in <= run_q && cnt_q == 4'h0;
    if (go) {run_q, cnt_q} <= {1'b1, dly};
    else if (run_q && cnt_q != 4'h0) cnt_q <= cnt_q - 4'h1;
    else run_q <= 1'b0;
  end
endmodule // fsxu_host_model
`default_nettype wire

// ---- tb/fsxu_status_unit_monitor.sv ----
/* port checker of the status unit. assumes one clock and a sync reset. */
`timescale 1ns/100ps
`default_nettype none
module fsxu_status_unit_monitor #(
  parameter ADDR_W = 16
) (
  // clock and reset
  input wire logic              core_clk,
  input wire logic              rst,
  // status load
  input wire logic              status_load_instr,
  input wire logic              kernel_mode,
  input wire logic [15:0]       float_status_word,
  // operation and exceptions
  input wire logic              op_done_in,
  input wire logic              ex_div_zero,
  input wire logic              ex_bad_opcode,
  input wire logic              float_irq,
  input wire logic [3:0]        float_exception_code,
  input wire logic [ADDR_W-1:0] float_exception_address,
  // addressing
  input wire logic [2:0]        addr_mode,
  input wire logic [2:0]        ac_sel,
  input wire logic              ac_illegal,
  input wire logic [4:0]        auto_step
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  err_set_a:
    assert property (op_done_in && ex_div_zero && !status_load_instr |=> float_status_word[15]) else $error("no flag");
  div_code_a:
    assert property (op_done_in && ex_div_zero && !ex_bad_opcode && !ac_illegal && !status_load_instr
      |=> float_exception_code == 4'h4) else $error("bad code");
  err_keep_a:
    assert property (float_status_word[15] && !status_load_instr |=> float_status_word[15]) else $error("flag lost");
  irq_block_a:
    assert property (float_status_word[14] && !status_load_instr |=> !float_irq) else $error("irq leak");
  code_hold_a:
    assert property (!op_done_in |=> $stable(float_exception_code) && $stable(float_exception_address))
      else $error("code moved");
  ac_limit_a:
    assert property (ac_illegal == (ac_sel > (addr_mode == 3'h0 ? 3'h5 : 3'h3))) else $error("ac check");
  step_size_a:
    assert property (auto_step == (float_status_word[7] ? 5'h08 : 5'h04)) else $error("step");
  maint_lock_a:
    assert property (status_load_instr && !kernel_mode && !float_status_word[4] |=> !float_status_word[4])
      else $error("maint set");
endmodule // fsxu_status_unit_monitor
bind fsxu_status_unit fsxu_status_unit_monitor #(
  .ADDR_W(ADDR_W)
) mon (
  .core_clk                (core_clk),
  .rst                     (rst),
  .status_load_instr       (status_load_instr),
  .kernel_mode             (kernel_mode),
  .float_status_word       (float_status_word),
  .op_done_in              (op_done_in),
  .ex_div_zero             (ex_div_zero),
  .ex_bad_opcode           (ex_bad_opcode),
  .float_irq               (float_irq),
  .float_exception_code    (float_exception_code),
  .float_exception_address (float_exception_address),
  .addr_mode               (addr_mode),
  .ac_sel                  (ac_sel),
  .ac_illegal              (ac_illegal),
  .auto_step               (auto_step)
);
`default_nettype wire

// ---- tb/fsxu_status_unit_tb_top.sv ----
/* bench of the status unit with a host model. assumes nothing else. */
`timescale 1ns/100ps
`default_nettype none
module fsxu_status_unit_tb_top;
  logic core_clk = 0, rst = 1, go = 0, kernel_mode = 0, status_load_instr = 0, sys_reset_instr = 0;
  logic res_negative = 0, res_zero = 0, res_minus_zero = 0, ex_conv_carry = 0, ex_maint = 0;
  logic ex_div_zero = 0, ex_bad_opcode = 0, ex_overflow = 0, ex_underflow = 0, ex_conv_fail = 0;
  logic ex_undef_var = 0, op_start, op_done_in, ac_illegal, result_force_zero, busy, op_done, float_irq;
  logic double_precision_mode, long_integer_mode, chop_mode, maintenance_mode;
  logic [15:0] status_load_data = 0, op_addr = 0, float_status_word, float_exception_address;
  logic [8:0] irq_vector;
  logic [4:0] auto_step;
  logic [3:0] dly = 0, float_exception_code;
  logic [2:0] addr_mode = 0, ac_sel = 0;
  logic [55:0] frac_chopped = 0, frac_result;
  logic [63:0] fp_value = 64'h0123456789abcdef;
  logic [15:0] mem_word;
  logic [1:0] mem_word_sel = 0;
  logic round_bit = 0, frac_carry;
  localparam logic [27:0] CODES = 28'hec6a842;
  int fail_count = 0, check_count = 0;
  fsxu_status_unit #(.ADDR_W(16)) uut (.*);
  fsxu_host_model host (.*);
  always #10 core_clk = ~core_clk;
  task chk(input [63:0] got, exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: %h, expected %h", $time, got, exp);
    end
  endtask
  task ld(input [15:0] d, input k);
    @(posedge core_clk) {status_load_data, kernel_mode, status_load_instr} <= {d, k, 1'b1};
    @(posedge core_clk) status_load_instr <= 1'b0;
    @(negedge core_clk);
  endtask
  // e: carry, zero, neg, maint, undef, conv, under, over, div0, opcode
  task op(input [9:0] e, input [15:0] a, input [3:0] d, input q);
    @(posedge core_clk) {op_addr, dly, go} <= {a, d, 1'b1};
    {ex_conv_carry, res_zero, res_negative, ex_maint, ex_undef_var, ex_conv_fail,
      ex_underflow, ex_overflow, ex_div_zero, ex_bad_opcode} <= e;
    @(posedge core_clk) go <= 1'b0;
    for (int n = 0; n < 20 && op_done !== 1'b1; n++) @(negedge core_clk);
    chk(op_done, 1'b1);
    chk(busy, 1'b1);
    @(negedge core_clk) chk(float_irq, q);
    chk(busy, 1'b0);
  endtask
  task rnd(input [55:0] f, input r, input [1:0] s);
    @(posedge core_clk) {frac_chopped, round_bit, mem_word_sel} <= {f, r, s};
    @(posedge core_clk);
    @(negedge core_clk);
  endtask
  task give_verdict;
    $display("checks %0d, mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    #100000;
    fail_count++;
    give_verdict;
  end
  initial begin
    repeat (8) @(posedge core_clk);
    rst <= 1'b0;
    @(negedge core_clk) chk(float_status_word, 16'h0000);
    chk(irq_vector, 9'h0a4);
    ld(16'hffff, 1'b0);
    chk(float_status_word, 16'hcfef);
    ld(16'h0f10, 1'b1);
    for (int i = 0; i < 7; i++) begin
      op(10'h1 << i, 16'h1000 + i, i % 3, 1'b1);
      chk(float_exception_code, CODES[4 * i +: 4]);
      chk(float_exception_address, 16'h1000 + i);
      chk(float_status_word, i == 2 ? 16'h8f12 : i == 4 ? 16'h8f14 : 16'h8f10);
      chk(result_force_zero, i == 4);
    end
    op(10'h003, 16'h1111, 4'h2, 1'b1);
    chk(float_exception_code, 4'h2);
    ld(16'h0000, 1'b1);
    op(10'h384, 16'h2222, 4'h1, 1'b0);
    chk(float_status_word, 16'h0007);
    chk(result_force_zero, 1'b1);
    chk(float_exception_address, 16'h1111);
    ld(16'h4000, 1'b1);
    op(10'h002, 16'h3333, 4'h0, 1'b0);
    chk(float_exception_address, 16'h3333);
    @(posedge core_clk) sys_reset_instr <= 1'b1;
    @(posedge core_clk) sys_reset_instr <= 1'b0;
    @(negedge core_clk) chk(float_status_word, 16'hc000);
    ld(16'h00e0, 1'b1);
    chk({double_precision_mode, long_integer_mode, chop_mode, maintenance_mode}, 4'he);
    chk(auto_step, 5'h08);
    rnd(56'hffffffffffffff, 1'b1, 2'h0);
    chk(frac_result, 56'hffffffffffffff);
    chk(frac_carry, 1'b0);
    chk(mem_word, 16'h0123);
    ld(16'h0080, 1'b1);
    rnd(56'hffffffffffffff, 1'b1, 2'h3);
    chk(frac_result, 56'h00000000000000);
    chk(frac_carry, 1'b1);
    chk(mem_word, 16'hcdef);
    ld(16'h0000, 1'b1);
    chk(auto_step, 5'h04);
    rnd(56'h12345678abcdef, 1'b1, 2'h1);
    chk(frac_result, 56'h12345700000000);
    chk(frac_carry, 1'b0);
    chk(mem_word, 16'h4567);
    rnd(56'h12345678abcdef, 1'b0, 2'h2);
    chk(frac_result, 56'h12345600000000);
    chk(mem_word, 16'h89ab);
    for (int m = 0; m < 2; m++)
      for (int a = 0; a < 8; a++) begin
        @(posedge core_clk) {addr_mode, ac_sel} <= {m[2:0], a[2:0]};
        @(negedge core_clk) chk(ac_illegal, a > (m ? 3 : 5));
      end
    op(10'h000, 16'h4444, 4'h0, 1'b1);
    chk(float_exception_code, 4'h2);
    give_verdict;
  end
endmodule // fsxu_status_unit_tb_top
`default_nettype wire
